// file: src/eep_pkg.sv
package eep_pkg;

   // ----------------------------------------------------------------
   // control byte layout and address pointer
   // ----------------------------------------------------------------
   localparam int unsigned EEP_ADDR_W    = 16;
   localparam int unsigned EEP_RW_POS    = 0;
   localparam int unsigned EEP_CS_LSB    = 1;
   localparam int unsigned EEP_TYPE_LSB  = 4;
   localparam logic [3:0]  EEP_DEV_TYPE  = 4'h5;      // arbitrary device-type code
   localparam logic [15:0] EEP_PTR_RST   = 16'h0000;
   localparam logic [3:0]  EEP_ACK_SLOT  = 4'h8;      // ninth clock of a byte
   localparam logic [3:0]  EEP_LAST_BIT  = 4'h7;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int unsigned EEP_CLK_KHZ    = 10000;
   localparam int unsigned EEP_WR_TIME_US = 200;
   localparam int unsigned EEP_WR_CYCLES  = (EEP_WR_TIME_US * EEP_CLK_KHZ) / 1000;
   localparam int unsigned EEP_TMR_W      = 16;
   localparam int unsigned EEP_QTR_DIV    = 2;        // clk cycles per quarter of scl

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      EEP_ST_IDLE = 3'b000,
      EEP_ST_CTRL = 3'b001,
      EEP_ST_AHI  = 3'b010,
      EEP_ST_ALO  = 3'b011,
      EEP_ST_WDAT = 3'b100,
      EEP_ST_RDAT = 3'b101,
      EEP_ST_RACK = 3'b110
   } eep_dev_st_e;

   typedef enum logic [1:0] {
      EEP_H_IDLE  = 2'b00,
      EEP_H_START = 2'b01,
      EEP_H_BIT   = 2'b10,
      EEP_H_STOP  = 2'b11
   } eep_host_st_e;

   typedef enum logic [2:0] {
      EEP_CMD_START = 3'b000,
      EEP_CMD_POLL  = 3'b001,
      EEP_CMD_WRITE = 3'b010,
      EEP_CMD_READ  = 3'b011,
      EEP_CMD_STOP  = 3'b100
   } eep_cmd_e;

endpackage

// file: src/eep_link_if.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// two-wire link: wired-and data line resolved from both enables
// ----------------------------------------------------------------
interface eep_link_if;
   logic scl;
   logic host_sda_oe;
   logic dev_sda_oe;
   logic sda;

   // open drain: any enabled driver pulls low, otherwise pulled up
   assign sda = ~(host_sda_oe | dev_sda_oe);

   modport host (output scl, output host_sda_oe, input sda);
   modport dev  (input scl, output dev_sda_oe, input sda);
endinterface

// file: src/eep_cond.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// start / stop detector, clocked by data-line edges
// ----------------------------------------------------------------
module eep_cond import eep_pkg::*; (
   input  wire logic rst_n,
   input  wire logic scl,
   input  wire logic sda,
   input  wire logic wrote,
   output logic      start_tgl,
   output logic      stop_tgl,
   output logic      prog_tgl
);

   // falling data while clock high is a start
   always_ff @(negedge sda or negedge rst_n) begin
      if (!rst_n) begin
         start_tgl <= 1'b0;
      end else if (scl) begin
         start_tgl <= ~start_tgl;
      end
   end

   // rising data while clock high is a stop; wrote is stable here since scl idles
   always_ff @(posedge sda or negedge rst_n) begin
      if (!rst_n) begin
         stop_tgl <= 1'b0;
         prog_tgl <= 1'b0;
      end else if (scl) begin
         stop_tgl <= ~stop_tgl;
         if (wrote) begin
            prog_tgl <= ~prog_tgl;
         end
      end
   end

endmodule // eep_cond

// file: src/eep_dev.sv
`timescale 1ns/1ps
// Behaviour
// - no acknowledge during internal write cycle
// - stop after write starts timed programming
// - host polls with start and write control
// - host repeats poll until acknowledged
// - acknowledge poll after programming, then continue
// - read framed like write, rw bit one
// - pointer holds last accessed address plus one
// - current read: ack control, send byte
// - random read loads pointer before repeated start
// - after restart, ack read control, send byte
// - random read leaves pointer past read byte
// - host acknowledge requests next sequential byte
// - host ends sequential read with nack, stop
// - pointer increments after every byte operation
// - pointer wraps from FFFF to 0000
// - control byte needs type and chip select
// - word address two bytes, high first
// - release data line after host nack
module eep_dev import eep_pkg::*; #(
   parameter logic [3:0]  DEV_TYPE  = EEP_DEV_TYPE,
   parameter int unsigned WR_CYCLES = EEP_WR_CYCLES
) (
   input  wire logic  clk,
   input  wire logic  rst_n,
   eep_link_if.dev    link,
   input  wire logic  [2:0] chip_sel_pins,
   output logic       prog_busy
);

   // ----------------------------------------------------------------
   // state types
   // ----------------------------------------------------------------
   typedef struct packed {
      eep_dev_st_e st;
      logic [3:0]  cnt;
      logic [7:0]  sh;
      logic [15:0] ptr;
      logic        rw;
      logic        drv;
      logic        wrote;
      logic        start_seen;
      logic        stop_seen;
      logic        busy_m;
      logic        busy_s;
      logic [2:0]  cs_m;
      logic [2:0]  cs_s;
   } eep_lnk_s;

   typedef struct packed {
      logic                 prog_m;
      logic                 prog_s;
      logic                 prog_d;
      logic                 busy;
      logic [EEP_TMR_W-1:0] tmr;
   } eep_sys_s;

   localparam logic [EEP_TMR_W-1:0] TMR_LOAD = EEP_TMR_W'(WR_CYCLES - 1);

   eep_lnk_s   l_ff;
   eep_lnk_s   nxt_l;
   eep_sys_s   s_ff;
   eep_sys_s   nxt_s;
   logic [7:0] mem [0:(1 << EEP_ADDR_W) - 1];
   logic       mem_we;
   logic [7:0] byte_in;
   logic [7:0] rd_byte;
   logic       start_tgl;
   logic       stop_tgl;
   logic       prog_tgl;
   logic       sda_oe_ff;

   // ----------------------------------------------------------------
   // control byte match
   // ----------------------------------------------------------------
   function automatic logic ctrl_hit(input logic [7:0] b,
                                     input logic [2:0] cs,
                                     input logic       busy);
      ctrl_hit = (b[EEP_TYPE_LSB +: 4] == DEV_TYPE)
              && (b[EEP_CS_LSB +: 3] == cs)
              && !busy;
   endfunction

   // ----------------------------------------------------------------
   // start / stop detection
   // ----------------------------------------------------------------
   eep_cond u_cond (
      .rst_n     (rst_n),
      .scl       (link.scl),
      .sda       (link.sda),
      .wrote     (l_ff.wrote),
      .start_tgl (start_tgl),
      .stop_tgl  (stop_tgl),
      .prog_tgl  (prog_tgl)
   );

   // ----------------------------------------------------------------
   // link side: bit engine on the rising serial clock
   // ----------------------------------------------------------------
   assign byte_in = {l_ff.sh[6:0], link.sda};
   assign rd_byte = mem[l_ff.ptr];

   // condition toggles settle while scl is high and stay put through the low
   // phase, so they are stable at the next rising edge that reads them
   always_comb begin
      nxt_l        = l_ff;
      mem_we       = 1'b0;
      nxt_l.busy_m = s_ff.busy;
      nxt_l.busy_s = l_ff.busy_m;
      nxt_l.cs_m   = chip_sel_pins;
      nxt_l.cs_s   = l_ff.cs_m;
      if (start_tgl != l_ff.start_seen) begin
         // this edge already carries the first control bit
         nxt_l.start_seen = start_tgl;
         nxt_l.stop_seen  = stop_tgl;
         nxt_l.st         = EEP_ST_CTRL;
         nxt_l.sh         = {7'h00, link.sda};
         nxt_l.cnt        = 4'h1;
         nxt_l.drv        = 1'b0;
         nxt_l.wrote      = 1'b0;
      end else if (stop_tgl != l_ff.stop_seen) begin
         nxt_l.stop_seen = stop_tgl;
         nxt_l.st        = EEP_ST_IDLE;
         nxt_l.drv       = 1'b0;
      end else begin
         case (l_ff.st)
            EEP_ST_CTRL, EEP_ST_AHI, EEP_ST_ALO, EEP_ST_WDAT: begin
               if (l_ff.cnt != EEP_ACK_SLOT) begin
                  nxt_l.sh  = byte_in;
                  nxt_l.cnt = l_ff.cnt + 4'h1;
                  if (l_ff.cnt == EEP_LAST_BIT) begin
                     nxt_l.drv = 1'b1;
                     case (l_ff.st)
                        EEP_ST_CTRL: begin
                           if (!ctrl_hit(byte_in, l_ff.cs_s, l_ff.busy_s)) begin
                              nxt_l.st  = EEP_ST_IDLE;
                              nxt_l.drv = 1'b0;
                           end else begin
                              nxt_l.rw = byte_in[EEP_RW_POS];
                           end
                        end
                        EEP_ST_AHI: nxt_l.ptr[15:8] = byte_in;
                        EEP_ST_ALO: nxt_l.ptr[7:0]  = byte_in;
                        default: begin
                           // data goes straight to the array; no page buffer
                           mem_we      = 1'b1;
                           nxt_l.ptr   = l_ff.ptr + 16'h0001;
                           nxt_l.wrote = 1'b1;
                        end
                     endcase
                  end
               end else begin
                  // ack clock done: release and move on
                  nxt_l.cnt = 4'h0;
                  nxt_l.drv = 1'b0;
                  case (l_ff.st)
                     EEP_ST_CTRL: begin
                        if (l_ff.rw) begin
                           nxt_l.st  = EEP_ST_RDAT;
                           nxt_l.sh  = rd_byte;
                           nxt_l.drv = ~rd_byte[7];
                        end else begin
                           nxt_l.st = EEP_ST_AHI;
                        end
                     end
                     EEP_ST_AHI: nxt_l.st = EEP_ST_ALO;
                     EEP_ST_ALO: nxt_l.st = EEP_ST_WDAT;
                     default:    nxt_l.st = EEP_ST_WDAT;
                  endcase
               end
            end
            EEP_ST_RDAT: begin
               if (l_ff.cnt == EEP_LAST_BIT) begin
                  nxt_l.drv = 1'b0;                        // leave the ack slot free
                  nxt_l.ptr = l_ff.ptr + 16'h0001;
                  nxt_l.cnt = 4'h0;
                  nxt_l.st  = EEP_ST_RACK;
               end else begin
                  nxt_l.sh  = {l_ff.sh[6:0], 1'b0};
                  nxt_l.drv = ~l_ff.sh[6];
                  nxt_l.cnt = l_ff.cnt + 4'h1;
               end
            end
            EEP_ST_RACK: begin
               if (!link.sda) begin
                  nxt_l.st  = EEP_ST_RDAT;
                  nxt_l.sh  = rd_byte;
                  nxt_l.drv = ~rd_byte[7];
               end else begin
                  nxt_l.st  = EEP_ST_IDLE;
                  nxt_l.drv = 1'b0;
               end
            end
            default: nxt_l.drv = 1'b0;
         endcase
      end
   end

   // link registers
   always_ff @(posedge link.scl or negedge rst_n) begin
      if (!rst_n) begin
         l_ff <= '{st: EEP_ST_IDLE, ptr: EEP_PTR_RST, default: '0};
      end else begin
         l_ff <= nxt_l;
      end
   end

   // array write, no reset on storage
   always_ff @(posedge link.scl) begin
      if (mem_we) begin
         mem[l_ff.ptr] <= byte_in;
      end
   end

   // data line only changes while the clock is low
   always_ff @(negedge link.scl or negedge rst_n) begin
      if (!rst_n) begin
         sda_oe_ff <= 1'b0;
      end else begin
         sda_oe_ff <= l_ff.drv;
      end
   end

   assign link.dev_sda_oe = sda_oe_ff;

   // ----------------------------------------------------------------
   // system side: programming timer
   // ----------------------------------------------------------------
   // the link clock stands still after stop, so the stop itself hands the
   // write over to this domain through a toggle
   always_comb begin
      nxt_s        = s_ff;
      nxt_s.prog_m = prog_tgl;
      nxt_s.prog_s = s_ff.prog_m;
      nxt_s.prog_d = s_ff.prog_s;
      if (s_ff.prog_s != s_ff.prog_d) begin
         nxt_s.busy = 1'b1;
         nxt_s.tmr  = TMR_LOAD;
      end else if (s_ff.busy) begin
         if (s_ff.tmr == '0) begin
            nxt_s.busy = 1'b0;
         end else begin
            nxt_s.tmr = s_ff.tmr - 1'b1;
         end
      end
   end

   // system registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign prog_busy = s_ff.busy;

endmodule // eep_dev

// file: src/eep_host.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// two-wire host: byte commands, clock made by dividing clk
// ----------------------------------------------------------------
module eep_host import eep_pkg::*; #(
   parameter int unsigned QTR_DIV = EEP_QTR_DIV
) (
   input  wire logic  clk,
   input  wire logic  rst_n,
   eep_link_if.host   link,
   input  wire logic  cmd_valid,
   output logic       cmd_ready,
   input  wire logic  [2:0] cmd_op,
   input  wire logic  [7:0] cmd_data,
   output logic       rsp_valid,
   output logic       [7:0] rsp_data,
   output logic       rsp_ack
);

   localparam logic [7:0] DIV_LAST = 8'(QTR_DIV - 1);

   typedef struct packed {
      eep_host_st_e st;
      logic [7:0]   div;
      logic [1:0]   q;
      logic [3:0]   bc;
      logic [8:0]   tx;
      logic [8:0]   rx;
      logic [2:0]   op;
      logic [7:0]   ctrl;
      logic         scl;
      logic         oe;
      logic         sda_m;
      logic         sda_s;
      logic         rsp_v;
      logic [7:0]   rsp_d;
      logic         rsp_a;
   } eep_hst_s;

   eep_hst_s h_ff;
   eep_hst_s nxt_h;
   logic     tick;
   logic [8:0] rx_next;

   assign tick      = (h_ff.div == DIV_LAST);
   assign rx_next   = {h_ff.rx[7:0], h_ff.sda_s};
   assign cmd_ready = (h_ff.st == EEP_H_IDLE);

   // quarter-phase sequencer: q0 low, q1 high, q2 high + sample, q3 low
   always_comb begin
      nxt_h       = h_ff;
      nxt_h.rsp_v = 1'b0;
      nxt_h.sda_m = link.sda;
      nxt_h.sda_s = h_ff.sda_m;
      nxt_h.div   = tick ? 8'h00 : h_ff.div + 8'h01;
      if (tick && h_ff.st != EEP_H_IDLE) begin
         nxt_h.q = h_ff.q + 2'b01;
      end
      case (h_ff.st)
         EEP_H_IDLE: begin
            nxt_h.div = 8'h00;
            nxt_h.q   = 2'b00;
            nxt_h.bc  = 4'h0;
            if (cmd_valid) begin
               nxt_h.op = cmd_op;
               nxt_h.tx = {cmd_data, 1'b1};
               case (cmd_op)
                  EEP_CMD_START, EEP_CMD_POLL: begin
                     nxt_h.st   = EEP_H_START;
                     nxt_h.ctrl = cmd_data;
                  end
                  EEP_CMD_WRITE: nxt_h.st = EEP_H_BIT;
                  EEP_CMD_READ: begin
                     nxt_h.st = EEP_H_BIT;
                     nxt_h.tx = {8'hFF, ~cmd_data[0]};
                  end
                  default: nxt_h.st = EEP_H_STOP;
               endcase
            end
         end
         EEP_H_START: begin
            if (tick) begin
               case (h_ff.q)
                  2'b00:   begin nxt_h.scl = 1'b0; nxt_h.oe = 1'b0; end
                  2'b01:   nxt_h.scl = 1'b1;
                  2'b10:   nxt_h.oe = 1'b1;                 // data falls, clock high
                  default: begin
                     // clock drops a quarter early so the first bit never moves with it
                     nxt_h.scl = 1'b0;
                     nxt_h.st  = EEP_H_BIT;
                  end
               endcase
            end
         end
         EEP_H_BIT: begin
            if (tick) begin
               case (h_ff.q)
                  2'b00:   begin nxt_h.scl = 1'b0; nxt_h.oe = ~h_ff.tx[8]; end
                  2'b01:   nxt_h.scl = 1'b1;
                  2'b10:   nxt_h.rx = rx_next;
                  default: begin
                     nxt_h.scl = 1'b0;
                     nxt_h.tx  = {h_ff.tx[7:0], 1'b1};
                     nxt_h.bc  = h_ff.bc + 4'h1;
                     if (h_ff.bc == EEP_ACK_SLOT) begin
                        if (h_ff.op == EEP_CMD_POLL && h_ff.rx[0]) begin
                           nxt_h.st = EEP_H_START;
                           nxt_h.tx = {h_ff.ctrl, 1'b1};
                           nxt_h.bc = 4'h0;
                        end else begin
                           nxt_h.st    = EEP_H_IDLE;
                           nxt_h.rsp_v = 1'b1;
                           nxt_h.rsp_d = h_ff.rx[8:1];
                           nxt_h.rsp_a = ~h_ff.rx[0];
                        end
                     end
                  end
               endcase
            end
         end
         default: begin
            if (tick) begin
               case (h_ff.q)
                  2'b00:   begin nxt_h.scl = 1'b0; nxt_h.oe = 1'b1; end
                  2'b01:   nxt_h.scl = 1'b1;
                  2'b10:   nxt_h.oe = 1'b0;                 // data rises, clock high
                  default: nxt_h.st = EEP_H_IDLE;
               endcase
            end
         end
      endcase
   end

   // host registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         h_ff <= '{st: EEP_H_IDLE, scl: 1'b1, default: '0};
      end else begin
         h_ff <= nxt_h;
      end
   end

   assign link.scl         = h_ff.scl;
   assign link.host_sda_oe = h_ff.oe;
   assign rsp_valid        = h_ff.rsp_v;
   assign rsp_data         = h_ff.rsp_d;
   assign rsp_ack          = h_ff.rsp_a;

endmodule // eep_host

// file: verif/eep_link_properties.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// link checker: watches both ends across the two-wire interface
// ----------------------------------------------------------------
module eep_link_properties import eep_pkg::*; #(
   parameter int unsigned WR_CYCLES = EEP_WR_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic scl,
   input wire logic host_sda_oe,
   input wire logic dev_sda_oe,
   input wire logic sda,
   input wire logic prog_busy
);
   typedef struct packed {
      logic        scl_q;
      logic        sda_q;
      logic [3:0]  rises;
      logic [7:0]  since_stop;
      logic [15:0] busy_len;
   } eep_chk_s;

   eep_chk_s chk_ff;
   eep_chk_s nxt_chk;
   logic     start_seen;
   logic     stop_seen;

   // conditions seen on clk samples; data only moves with scl high at start or stop
   assign start_seen = scl & chk_ff.scl_q & chk_ff.sda_q & ~sda;
   assign stop_seen  = scl & chk_ff.scl_q & ~chk_ff.sda_q & sda;

   // since_stop and rises saturate so a long idle never wraps into a false match
   always_comb begin
      nxt_chk = chk_ff;
      nxt_chk.scl_q = scl;
      nxt_chk.sda_q = sda;
      if (stop_seen) begin
         nxt_chk.since_stop = 8'h00;
      end else if (chk_ff.since_stop != 8'hff) begin
         nxt_chk.since_stop = chk_ff.since_stop + 8'h01;
      end
      if (start_seen) begin
         nxt_chk.rises = 4'h0;
      end else if (scl && !chk_ff.scl_q && chk_ff.rises != 4'hf) begin
         nxt_chk.rises = chk_ff.rises + 4'h1;
      end
      nxt_chk.busy_len = prog_busy ? chk_ff.busy_len + 16'h0001 : 16'h0000;
   end

   // helper state register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         chk_ff <= '{1'b1, 1'b1, 4'hf, 8'hff, 16'h0000};
      end else begin
         chk_ff <= nxt_chk;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_busy_no_ack: assert property (prog_busy |-> !dev_sda_oe)
      else $error("device drives data line while programming");
   a_prog_after_stop: assert property ($rose(prog_busy) |-> chk_ff.since_stop <= 8'h08)
      else $error("programming started without a recent stop");
   a_prog_length: assert property ($fell(prog_busy) |->
      chk_ff.busy_len >= 16'(WR_CYCLES - 1) && chk_ff.busy_len <= 16'(WR_CYCLES + 1))
      else $error("programming time differs from write cycle count");
   a_start_rx_idle: assert property (start_seen |-> !dev_sda_oe [*8])
      else $error("device drives data line right after start");
   a_dev_bit_stable: assert property (scl && chk_ff.scl_q |-> $stable(dev_sda_oe))
      else $error("device changed data line while clock high");
   a_ack_after_ctrl: assert property ($rose(dev_sda_oe) |-> chk_ff.rises >= 4'h8)
      else $error("device answered before a full control byte");
   a_scl_high_width: assert property ($rose(scl) |-> scl [*4])
      else $error("serial clock high phase too short");
   a_stop_bus_idle: assert property (stop_seen |-> scl [*3])
      else $error("serial clock fell right after stop");
   a_no_line_clash: assert property (scl && dev_sda_oe |-> !host_sda_oe)
      else $error("host and device both pull data line while clock high");

   cover property ($rose(prog_busy));
   cover property (start_seen);
   cover property ($rose(dev_sda_oe) && chk_ff.rises == 4'h8);
endmodule // eep_link_properties

// file: verif/test_serial_eeprom_read_and_poll.sv
`timescale 1ns/1ps
module test_serial_eeprom_read_and_poll;
   import eep_pkg::*;
   localparam int unsigned WR_CYC = 400;  // short write time keeps polls brief
   localparam logic [2:0]  CSEL   = 3'h5;
   localparam int          LIM    = 30000;

   logic       clk;
   logic       rst_n;
   logic       cmd_valid;
   logic       cmd_ready;
   logic [2:0] cmd_op;
   logic [7:0] cmd_data;
   logic       rsp_valid;
   logic [7:0] rsp_data;
   logic       rsp_ack;
   logic       prog_busy;
   logic [7:0] got;
   logic       ackd;
   int         num_errors;
   int         n_checks;
   logic [7:0] tv [5] = '{8'ha5, 8'h3c, 8'h0f, 8'he1, 8'h77};

   eep_link_if link ();
   eep_host eep_host_inst (.clk(clk), .rst_n(rst_n), .link(link), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
      .rsp_data(rsp_data), .rsp_ack(rsp_ack));
   eep_dev #(.WR_CYCLES(WR_CYC)) eep_dev_inst (.clk(clk), .rst_n(rst_n), .link(link),
      .chip_sel_pins(CSEL), .prog_busy(prog_busy));
   eep_link_properties #(.WR_CYCLES(WR_CYC)) eep_link_properties_inst (.clk(clk),
      .rst_n(rst_n), .scl(link.scl), .host_sda_oe(link.host_sda_oe),
      .dev_sda_oe(link.dev_sda_oe), .sda(link.sda), .prog_busy(prog_busy));

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic close_out();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // one host command, entered at a falling edge; stop has no response pulse
   task automatic cmd(input eep_cmd_e op, input logic [7:0] d);
      int n;
      n = 0;
      while (cmd_ready !== 1'b1 && n < LIM) begin
         @(negedge clk);
         n++;
      end
      cmd_valid = 1'b1;
      cmd_op = op;
      cmd_data = d;
      @(negedge clk);
      cmd_valid = 1'b0;
      while (((op == EEP_CMD_STOP) ? cmd_ready : rsp_valid) !== 1'b1 && n < LIM) begin
         @(negedge clk);
         n++;
      end
      if (n >= LIM) begin
         num_errors++;
         close_out();
      end
      got = rsp_data;
      ackd = rsp_ack;
   endtask

   task automatic start_ctrl(input logic [2:0] cs, input logic rw, input logic exp);
      cmd(EEP_CMD_START, {EEP_DEV_TYPE, cs, rw});
      check("control ack", ackd, exp);
   endtask

   task automatic addr_bytes(input logic [15:0] a);
      cmd(EEP_CMD_WRITE, a[15:8]);
      check("addr high ack", ackd, 1'b1);
      cmd(EEP_CMD_WRITE, a[7:0]);
      check("addr low ack", ackd, 1'b1);
   endtask

   task automatic read_byte(input logic host_ack, input logic [7:0] exp);
      cmd(EEP_CMD_READ, {7'h00, host_ack});
      check("read data", got, exp);
      check("host ack bit", ackd, host_ack);
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   // wrong chip select, then wrong type code: both ignored
   task automatic sc_select();
      start_ctrl(CSEL ^ 3'h1, 1'b0, 1'b0);
      cmd(EEP_CMD_STOP, 8'h00);
      cmd(EEP_CMD_START, {~EEP_DEV_TYPE, CSEL, 1'b0});
      check("bad type ack", ackd, 1'b0);
      cmd(EEP_CMD_STOP, 8'h00);
   endtask

   // five bytes across the top of the array, then a read attempt while busy
   task automatic sc_write();
      start_ctrl(CSEL, 1'b0, 1'b1);
      addr_bytes(16'hfffe);
      for (int i = 0; i < 5; i++) begin
         cmd(EEP_CMD_WRITE, tv[i]);
         check("data ack", ackd, 1'b1);
      end
      cmd(EEP_CMD_STOP, 8'h00);
      repeat (4) @(negedge clk);
      check("busy after stop", prog_busy, 1'b1);
      start_ctrl(CSEL, 1'b1, 1'b0);
      cmd(EEP_CMD_STOP, 8'h00);
   endtask

   // poll until acked, carry on with a random then sequential read over the wrap
   task automatic sc_poll_read();
      cmd(EEP_CMD_POLL, {EEP_DEV_TYPE, CSEL, 1'b0});
      check("poll ack", ackd, 1'b1);
      check("busy after poll", prog_busy, 1'b0);
      addr_bytes(16'hfffe);
      start_ctrl(CSEL, 1'b1, 1'b1);
      for (int i = 0; i < 4; i++) begin
         read_byte(i < 3, tv[i]);
      end
      check("line released", link.sda, 1'b1);
      cmd(EEP_CMD_STOP, 8'h00);
   endtask

   // current reads follow the pointer left by the previous access
   task automatic sc_current();
      start_ctrl(CSEL, 1'b1, 1'b1);
      read_byte(1'b0, tv[4]);
      cmd(EEP_CMD_STOP, 8'h00);
      start_ctrl(CSEL, 1'b0, 1'b1);
      addr_bytes(16'h0000);
      start_ctrl(CSEL, 1'b1, 1'b1);
      read_byte(1'b0, tv[2]);
      cmd(EEP_CMD_STOP, 8'h00);
      start_ctrl(CSEL, 1'b1, 1'b1);
      read_byte(1'b0, tv[3]);
      cmd(EEP_CMD_STOP, 8'h00);
   endtask

   // ----------------------------------------------------------------
   // clock, reset and sequence
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   initial begin
      rst_n = 1'b0;
      cmd_valid = 1'b0;
      cmd_op = EEP_CMD_STOP;
      cmd_data = 8'h00;
      num_errors = 0;
      n_checks = 0;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      sc_select();
      sc_write();
      sc_poll_read();
      sc_current();
      close_out();
   end
endmodule // test_serial_eeprom_read_and_poll
